// file: pll_synth_pkg.sv
// shared constants and types for the counter-based clock synthesizer
package pll_synth_pkg;
	localparam int REG_ADDR_W   = 8;
	localparam int REG_DATA_W   = 32;
	localparam int FACTOR_W     = 10;
	localparam int DIV_FIELD_W  = 9;
	localparam int DIV_SUM_W    = 10;
	localparam int PERIOD_W     = 16;
	localparam int DIV_IDX_W    = 3;
	localparam int CTRL_W       = 8;

	localparam logic [FACTOR_W-1:0]    FACTOR_MAX     = 10'h200;
	localparam logic [DIV_FIELD_W-1:0] HALF_COUNT_MAX = 9'h100;
	localparam logic [DIV_SUM_W-1:0]   ODD_DUTY_MAX   = 10'h100;

	localparam logic [REG_ADDR_W-1:0] CTRL_OFS     = 8'h00;
	localparam logic [REG_ADDR_W-1:0] PRESCALE_OFS = 8'h04;
	localparam logic [REG_ADDR_W-1:0] MULT_OFS     = 8'h08;
	localparam logic [REG_ADDR_W-1:0] STATUS_OFS   = 8'h0C;
	localparam logic [REG_ADDR_W-1:0] DIV_BASE_OFS = 8'h10;

	localparam int MODE_LSB          = 0;
	localparam int MODE_W            = 3;
	localparam int OSC_HALVE_BIT     = 3;
	localparam int EXT_SEL_LSB       = 4;
	localparam int EXT_SEL_W         = 2;
	localparam int USER_IO_OUT_BIT   = 6;
	localparam int USER_IO_DRIVE_BIT = 7;
	localparam int RESTART_BIT       = 8;

	localparam int DIV_HIGH_LSB = 0;
	localparam int DIV_LOW_LSB  = 16;

	localparam int LOCKED_BIT    = 0;
	localparam int CFG_ERR_BIT   = 1;
	localparam int POS_PIN_BIT   = 2;
	localparam int NEG_PIN_BIT   = 3;
	localparam int CLK_LEVEL_LSB = 4;
	localparam int PERIOD_LSB    = 16;

	localparam logic [CTRL_W-1:0]      CTRL_RST     = 8'h00;
	localparam logic [FACTOR_W-1:0]    FACTOR_RST   = 10'h001;
	localparam logic [DIV_FIELD_W-1:0] DIV_HIGH_RST = 9'h001;
	localparam logic [DIV_FIELD_W-1:0] DIV_LOW_RST  = 9'h001;

	typedef enum logic [MODE_W-1:0] {
		MODE_NO_COMP,
		MODE_NORMAL,
		MODE_SRC_SYNC,
		MODE_ZERO_DELAY,
		MODE_DET_LATENCY
	} feedback_mode_type;

	typedef enum logic [EXT_SEL_W-1:0] {
		EXT_OFF,
		EXT_SINGLE,
		EXT_DIFF
	} ext_out_type;
endpackage : pll_synth_pkg

// file: modulo_counter.sv
// enabled modulo counter with a one-cycle wrap pulse
`timescale 1ns/100ps
`default_nettype none
module modulo_counter
	import pll_synth_pkg::*;
#(
	parameter int WIDTH = FACTOR_W
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             clear,
	input  wire logic             enable,
	input  wire logic [WIDTH-1:0] limit,
	output logic                  tick,
	output logic      [WIDTH-1:0] count
);
	logic [WIDTH-1:0] count_r;
	logic             tick_r;
	wire              atWrap = (count_r == WIDTH'(limit - 1'b1));

	always_ff @(posedge clock)
	begin
		if (reset || clear)
		begin
			count_r <= '0;
			tick_r  <= 1'b0;
		end
		else
		begin
			tick_r <= enable && atWrap;
			if (enable)
				count_r <= atWrap ? '0 : WIDTH'(count_r + 1'b1);
		end
	end

	assign tick  = tick_r;
	assign count = count_r;
endmodule : modulo_counter
`default_nettype wire

// file: post_scale_divider.sv
// high/low count divider stepping on input ticks
`timescale 1ns/100ps
`default_nettype none
module post_scale_divider
	import pll_synth_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   reset,
	input  wire logic                   restart,
	input  wire logic                   enable,
	input  wire logic                   inTick,
	input  wire logic [DIV_FIELD_W-1:0] highCount,
	input  wire logic [DIV_FIELD_W-1:0] lowCount,
	output logic                        clockOut,
	output logic                        periodTick
);
	logic [DIV_FIELD_W-1:0] count_r;
	logic                   highPhase_r;
	logic                   out_r;
	logic                   period_r;
	wire                    bypass   = (lowCount == '0);
	wire [DIV_FIELD_W-1:0]  phaseEnd = highPhase_r ? highCount : lowCount;
	wire                    lastStep = (count_r == DIV_FIELD_W'(phaseEnd - 1'b1));
	wire                    newPeriod = inTick && lastStep && (!highPhase_r || bypass);

	always_ff @(posedge clock)
	begin
		if (reset || restart || !enable)
		begin
			count_r     <= '0;
			highPhase_r <= 1'b1;
			out_r       <= 1'b0;
			period_r    <= 1'b0;
		end
		else
		begin
			period_r <= newPeriod;
			if (inTick)
			begin
				count_r <= lastStep ? '0 : DIV_FIELD_W'(count_r + 1'b1);
				if (lastStep && !bypass)
					highPhase_r <= !highPhase_r;
			end
			out_r <= bypass ? inTick : highPhase_r;
		end
	end

	assign clockOut   = out_r;
	assign periodTick = period_r;
endmodule : post_scale_divider
`default_nettype wire

// file: pll_counter_clock_synthesis.sv
// counter-based clock synthesis core with wishbone registers and output routing
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - one external clock output: single-ended or a differential pair
// - only divider zero drives the external output directly
// - other dividers reach pins only through the global clock outputs
// - differential negative pin is the inverse of the positive pin
// - single-ended use leaves the second pin as ordinary user I/O
// - five feedback modes, all keep multiply, divide and duty control
// - no-compensation mode keeps all internal clocks aligned to each other
// - reference is divided by the prescaler then multiplied by the multiplier
// - oscillator is driven toward input frequency times M over N
// - each output has its own post-scale divider of the oscillator
// - one prescaler and one multiplier, each accepting 1 through 512
// - prescaler only divides frequency, no duty control
// - five post-scale dividers feeding global or external outputs
// - divide 1..512 at 50% duty, 1..256 at any other duty
// - divide value is high count plus low count
// - dividers cascade output to next input beyond 512
// - cascade divides by the product of the settings
// - cascading fixed at build time, never changed at run time
// - duty set by separate high and low counts
// - duty step is 100% over the divide value
// - optional oscillator halving ahead of the output dividers
module pll_counter_clock_synthesis
	import pll_synth_pkg::*;
#(
	parameter int                      NUM_DIVIDERS = 5,
	parameter logic [NUM_DIVIDERS-2:0] CASCADE_MASK = '0
) (
	input  wire logic                    clock,
	input  wire logic                    reset,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [REG_ADDR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [REG_DATA_W-1:0]   wb_dat_i,
	output logic      [REG_DATA_W-1:0]   wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    refClockIn,
	output logic      [NUM_DIVIDERS-1:0] globalClockOut,
	input  wire logic                    extClockPosIn,
	output logic                         extClockPosOut,
	output logic                         extClockPosOeN,
	input  wire logic                    extClockNegIn,
	output logic                         extClockNegOut,
	output logic                         extClockNegOeN
);
	function automatic logic [REG_DATA_W-1:0] mergeBytes(
		input logic [REG_DATA_W-1:0] oldVal,
		input logic [REG_DATA_W-1:0] newVal,
		input logic [3:0]            sel
	);
		logic [REG_DATA_W-1:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				res[8*b +: 8] = newVal[8*b +: 8];
		return res;
	endfunction : mergeBytes

	// ---- register state
	logic [CTRL_W-1:0]      ctrl_r;
	logic [FACTOR_W-1:0]    prescale_r;
	logic [FACTOR_W-1:0]    mult_r;
	logic [DIV_FIELD_W-1:0] divHigh_r [NUM_DIVIDERS];
	logic [DIV_FIELD_W-1:0] divLow_r  [NUM_DIVIDERS];
	logic                   wbAck_r;
	logic [REG_DATA_W-1:0]  wbDat_r;

	// ---- pin synchronisers
	logic [1:0] refSync_r;
	logic       refPrev_r;
	logic [1:0] posSync_r;
	logic [1:0] negSync_r;

	// ---- loop state
	logic [PERIOD_W-1:0] periodCnt_r;
	logic [PERIOD_W-1:0] periodLat_r;
	logic [PERIOD_W-1:0] periodPrev_r;
	logic [PERIOD_W:0]   acc_r;
	logic                oscTick_r;
	logic                halfToggle_r;
	logic                locked_r;
	logic                alignPending_r;

	// ---- output flops
	logic [NUM_DIVIDERS-1:0] globalClock_r;
	logic                    posOut_r;
	logic                    posOeN_r;
	logic                    negOut_r;
	logic                    negOeN_r;

	// ---- bus decode
	wire request  = wb_cyc_i && wb_stb_i && !wbAck_r;
	wire wrEn     = request && wb_we_i;
	wire selCtrl  = (wb_adr_i == CTRL_OFS);
	wire selPre   = (wb_adr_i == PRESCALE_OFS);
	wire selMult  = (wb_adr_i == MULT_OFS);
	wire selStat  = (wb_adr_i == STATUS_OFS);
	wire [REG_ADDR_W-1:0] divOfs = REG_ADDR_W'(wb_adr_i - DIV_BASE_OFS);
	wire selDiv   = (wb_adr_i >= DIV_BASE_OFS) && (divOfs[1:0] == 2'b00)
		&& (divOfs[REG_ADDR_W-1:2] < (REG_ADDR_W-2)'(NUM_DIVIDERS));
	wire [DIV_IDX_W-1:0] divIdx = selDiv ? divOfs[DIV_IDX_W+1:2] : '0;

	wire [REG_DATA_W-1:0] divWord = {
		{(REG_DATA_W-DIV_LOW_LSB-DIV_FIELD_W){1'b0}}, divLow_r[divIdx],
		{(DIV_LOW_LSB-DIV_FIELD_W){1'b0}}, divHigh_r[divIdx]};
	wire [REG_DATA_W-1:0] ctrlMerged = mergeBytes(
		{{(REG_DATA_W-CTRL_W){1'b0}}, ctrl_r}, wb_dat_i, wb_sel_i);
	wire [REG_DATA_W-1:0] preMerged = mergeBytes(
		{{(REG_DATA_W-FACTOR_W){1'b0}}, prescale_r}, wb_dat_i, wb_sel_i);
	wire [REG_DATA_W-1:0] multMerged = mergeBytes(
		{{(REG_DATA_W-FACTOR_W){1'b0}}, mult_r}, wb_dat_i, wb_sel_i);
	wire [REG_DATA_W-1:0] divMerged = mergeBytes(divWord, wb_dat_i, wb_sel_i);
	wire restartReq = wrEn && selCtrl && wb_sel_i[RESTART_BIT/8] && wb_dat_i[RESTART_BIT];
	wire cfgWrite   = wrEn && (selPre || selMult || selDiv || restartReq);

	// ---- configuration checks and decoded controls
	wire preBad  = (prescale_r == '0) || (prescale_r > FACTOR_MAX);
	wire multBad = (mult_r == '0) || (mult_r > FACTOR_MAX);
	wire [FACTOR_W-1:0] prescaleEff = preBad ? FACTOR_RST : prescale_r;
	wire [FACTOR_W-1:0] multEff     = multBad ? FACTOR_RST : mult_r;
	wire [MODE_W-1:0]   modeRaw     = ctrl_r[MODE_LSB +: MODE_W];
	wire                modeBad     = (modeRaw > MODE_DET_LATENCY);
	feedback_mode_type  modeSel;
	ext_out_type        extSel;
	assign modeSel = feedback_mode_type'(modeRaw);
	assign extSel  = ext_out_type'(ctrl_r[EXT_SEL_LSB +: EXT_SEL_W]);
	wire oscHalve  = ctrl_r[OSC_HALVE_BIT];
	wire userIoOut = ctrl_r[USER_IO_OUT_BIT];
	wire userIoDrv = ctrl_r[USER_IO_DRIVE_BIT];

	logic [NUM_DIVIDERS-1:0] divBad;
	always_comb
	begin
		for (int i = 0; i < NUM_DIVIDERS; i++)
			divBad[i] = (divHigh_r[i] == '0) || (divHigh_r[i] > HALF_COUNT_MAX)
				|| (divLow_r[i] > HALF_COUNT_MAX)
				|| ((divHigh_r[i] != divLow_r[i])
				&& ((DIV_SUM_W'(divHigh_r[i]) + DIV_SUM_W'(divLow_r[i]))
				> ODD_DUTY_MAX));
	end
	wire cfgErr = preBad || multBad || modeBad || (|divBad);

	// ---- reference prescaler: division only, no duty control
	wire refEdge = refSync_r[1] && !refPrev_r;
	wire refTick;
	modulo_counter #(
		.WIDTH (FACTOR_W)
	) refPrescaler (
		.clock  (clock),
		.reset  (reset),
		.clear  (cfgWrite),
		.enable (refEdge),
		.limit  (prescaleEff),
		.tick   (refTick),
		.count  ()
	);

	// ---- feedback multiplier counts oscillator ticks between reference ticks
	wire [FACTOR_W-1:0] fbCount;
	modulo_counter #(
		.WIDTH (FACTOR_W)
	) fbMultiplier (
		.clock  (clock),
		.reset  (reset),
		.clear  (refTick),
		.enable (oscFire),
		.limit  (multEff),
		.tick   (),
		.count  (fbCount)
	);

	// ---- numeric oscillator: M ticks per period, the last one just before the reference tick
	wire [PERIOD_W:0] accSum    = acc_r + (PERIOD_W+1)'(multEff);
	wire [PERIOD_W:0] periodExt = {1'b0, periodLat_r};
	wire              oscFire   = (periodLat_r != '0) && (accSum >= periodExt);
	wire [PERIOD_W:0] accLeft   = accSum - periodExt;
	wire [PERIOD_W:0] acc_nxt   = refTick ? (PERIOD_W+1)'(multEff)
		: !oscFire ? accSum
		: (accLeft >= periodExt) ? '0 : accLeft;
	wire periodFull = (periodCnt_r == {PERIOD_W{1'b1}});
	wire oscTickDiv = oscTick_r && (!oscHalve || halfToggle_r);

	// ---- alignment restart; no-compensation restarts at once, others wait for the reference
	wire alignNow = alignPending_r && (modeSel == MODE_NO_COMP || refTick);
	wire alignPending_nxt = (alignPending_r && !alignNow) || cfgWrite;

	// ---- post-scale dividers
	wire [NUM_DIVIDERS-1:0] divClock;
	wire [NUM_DIVIDERS-1:0] divPeriod;
	wire [NUM_DIVIDERS-1:0] divInTick;
	genvar g;
	generate
		for (g = 0; g < NUM_DIVIDERS; g++)
		begin : gen_div
			if (g > 0)
			begin : gen_src
				assign divInTick[g] = CASCADE_MASK[g-1] ? divPeriod[g-1]
					: oscTickDiv;
			end
			else
			begin : gen_first
				assign divInTick[g] = oscTickDiv;
			end
			post_scale_divider divider (
				.clock      (clock),
				.reset      (reset),
				.restart    (alignNow),
				.enable     (!divBad[g]),
				.inTick     (divInTick[g]),
				.highCount  (divHigh_r[g]),
				.lowCount   (divLow_r[g]),
				.clockOut   (divClock[g]),
				.periodTick (divPeriod[g])
			);
		end
	endgenerate

	// ---- external pin routing from divider zero only
	wire extActive = (extSel == EXT_SINGLE) || (extSel == EXT_DIFF);
	wire posOut_nxt = extActive ? divClock[0] : 1'b0;
	wire posOeN_nxt = !extActive;
	wire negOut_nxt = (extSel == EXT_DIFF) ? !divClock[0] : userIoOut;
	wire negOeN_nxt = !((extSel == EXT_DIFF) || userIoDrv);

	// ---- read mux
	wire [REG_DATA_W-1:0] statusWord = {
		periodLat_r,
		{(PERIOD_LSB-CLK_LEVEL_LSB-NUM_DIVIDERS){1'b0}}, globalClock_r,
		negSync_r[1], posSync_r[1], cfgErr, locked_r};
	wire [REG_DATA_W-1:0] readData =
		selCtrl ? {{(REG_DATA_W-CTRL_W){1'b0}}, ctrl_r}
		: selPre ? {{(REG_DATA_W-FACTOR_W){1'b0}}, prescale_r}
		: selMult ? {{(REG_DATA_W-FACTOR_W){1'b0}}, mult_r}
		: selStat ? statusWord
		: selDiv ? divWord
		: '0;

	// ---- wishbone slave and register writes
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			wbAck_r <= 1'b0;
			wbDat_r <= '0;
		end
		else
		begin
			wbAck_r <= request;
			wbDat_r <= request ? readData : '0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ctrl_r     <= CTRL_RST;
			prescale_r <= FACTOR_RST;
			mult_r     <= FACTOR_RST;
		end
		else if (wrEn)
		begin
			if (selCtrl)
				ctrl_r <= ctrlMerged[CTRL_W-1:0];
			if (selPre)
				prescale_r <= preMerged[FACTOR_W-1:0];
			if (selMult)
				mult_r <= multMerged[FACTOR_W-1:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			for (int i = 0; i < NUM_DIVIDERS; i++)
			begin
				divHigh_r[i] <= DIV_HIGH_RST;
				divLow_r[i]  <= DIV_LOW_RST;
			end
		end
		else if (wrEn && selDiv)
		begin
			divHigh_r[divIdx] <= divMerged[DIV_HIGH_LSB +: DIV_FIELD_W];
			divLow_r[divIdx]  <= divMerged[DIV_LOW_LSB +: DIV_FIELD_W];
		end
	end

	// ---- synchronisers for pins
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			refSync_r <= '0;
			refPrev_r <= 1'b0;
			posSync_r <= '0;
			negSync_r <= '0;
		end
		else
		begin
			refSync_r <= {refSync_r[0], refClockIn};
			refPrev_r <= refSync_r[1];
			posSync_r <= {posSync_r[0], extClockPosIn};
			negSync_r <= {negSync_r[0], extClockNegIn};
		end
	end

	// ---- period measurement and lock
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			periodCnt_r  <= '0;
			periodLat_r  <= '0;
			periodPrev_r <= '0;
			locked_r     <= 1'b0;
		end
		else if (refTick)
		begin
			periodCnt_r  <= '0;
			periodLat_r  <= PERIOD_W'(periodCnt_r + 1'b1);
			periodPrev_r <= periodLat_r;
			locked_r     <= (fbCount == '0) && (periodLat_r == periodPrev_r)
				&& (periodLat_r != '0);
		end
		else
		begin
			if (!periodFull)
				periodCnt_r <= PERIOD_W'(periodCnt_r + 1'b1);
			if (cfgWrite || periodFull)
				locked_r <= 1'b0;
		end
	end

	// ---- oscillator accumulator and halving stage
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			acc_r          <= '0;
			oscTick_r      <= 1'b0;
			halfToggle_r   <= 1'b0;
			alignPending_r <= 1'b1;
		end
		else
		begin
			acc_r          <= acc_nxt;
			oscTick_r      <= oscFire && !refTick;
			alignPending_r <= alignPending_nxt;
			if (alignNow)
				halfToggle_r <= 1'b0;
			else if (oscTick_r)
				halfToggle_r <= !halfToggle_r;
		end
	end

	// ---- output flops
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			globalClock_r <= '0;
			posOut_r      <= 1'b0;
			posOeN_r      <= 1'b1;
			negOut_r      <= 1'b0;
			negOeN_r      <= 1'b1;
		end
		else
		begin
			globalClock_r <= divClock;
			posOut_r      <= posOut_nxt;
			posOeN_r      <= posOeN_nxt;
			negOut_r      <= negOut_nxt;
			negOeN_r      <= negOeN_nxt;
		end
	end

	assign wb_ack_o       = wbAck_r;
	assign wb_dat_o       = wbDat_r;
	assign globalClockOut = globalClock_r;
	assign extClockPosOut = posOut_r;
	assign extClockPosOeN = posOeN_r;
	assign extClockNegOut = negOut_r;
	assign extClockNegOeN = negOeN_r;
endmodule : pll_counter_clock_synthesis
`default_nettype wire

// file: pll_synth_assertions.sv
// port-level checker for the clock synthesis core
`timescale 1ns/100ps
`default_nettype none
module pll_synth_assertions
	import pll_synth_pkg::*;
#(
	parameter int NUM_DIVIDERS = 5
) (
	input wire logic                    clock,
	input wire logic                    reset,
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_we_i,
	input wire logic [REG_ADDR_W-1:0]   wb_adr_i,
	input wire logic [3:0]              wb_sel_i,
	input wire logic [REG_DATA_W-1:0]   wb_dat_i,
	input wire logic [REG_DATA_W-1:0]   wb_dat_o,
	input wire logic                    wb_ack_o,
	input wire logic [NUM_DIVIDERS-1:0] globalClockOut,
	input wire logic                    extClockPosOut,
	input wire logic                    extClockPosOeN,
	input wire logic                    extClockNegOut,
	input wire logic                    extClockNegOeN
);
	logic [7:0] ctrlSeen_r;
	logic [1:0] settle_r;
	wire        ctrlWrite;
	wire        steady;
	wire  [1:0] extSel;
	// shadow of the control byte, trusted once outputs had time to settle
	assign ctrlWrite = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == CTRL_OFS);
	assign steady = (settle_r == 2'h3);
	assign extSel = ctrlSeen_r[5:4];
	always_ff @(posedge clock)
	begin
		if (reset)
			settle_r <= 2'h0;
		else if (ctrlWrite)
			settle_r <= 2'h0;
		else if (!steady)
			settle_r <= settle_r + 2'h1;
	end
	always_ff @(posedge clock)
	begin
		if (reset)
			ctrlSeen_r <= CTRL_RST;
		else if (ctrlWrite)
			ctrlSeen_r <= wb_dat_i[7:0];
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data not zero outside ack");
	a_reset_quiet: assert property ($past(reset) |-> !wb_ack_o && globalClockOut == '0
		&& extClockPosOeN && extClockNegOeN)
		else $error("outputs active right after reset");
	a_pos_follows_div0: assert property (steady && (extSel == 2'h1 || extSel == 2'h2)
		|-> extClockPosOut == globalClockOut[0] && !extClockPosOeN)
		else $error("external output differs from divider zero");
	a_pos_off_quiet: assert property (steady && (extSel == 2'h0 || extSel == 2'h3)
		|-> !extClockPosOut && extClockPosOeN)
		else $error("external output active while off");
	a_neg_inverse: assert property (steady && extSel == EXT_DIFF
		|-> extClockNegOut != extClockPosOut && !extClockNegOeN)
		else $error("negative pin not inverse of positive pin");
	a_neg_user_io: assert property (steady && extSel != EXT_DIFF && ctrlSeen_r[7]
		|-> extClockNegOut == ctrlSeen_r[6] && !extClockNegOeN)
		else $error("negative pin not the user value");
	a_neg_released: assert property (steady && extSel != EXT_DIFF && !ctrlSeen_r[7]
		|-> extClockNegOeN)
		else $error("negative pin driven while unused");
	c_diff_mode: cover property (steady && extSel == EXT_DIFF && $rose(extClockPosOut));
	c_user_io: cover property (steady && ctrlSeen_r[7] && extClockNegOut);
	c_write_ack: cover property (wb_we_i && $rose(wb_ack_o));
endmodule : pll_synth_assertions
bind pll_counter_clock_synthesis pll_synth_assertions #(.NUM_DIVIDERS(NUM_DIVIDERS)) checker_i (
	.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .globalClockOut, .extClockPosOut, .extClockPosOeN,
	.extClockNegOut, .extClockNegOeN);
`default_nettype wire

// file: ref_clock_source.sv
// reference clock source that stands low while stopped
`timescale 1ns/100ps
`default_nettype none
module ref_clock_source (
	input  wire logic        clock,
	input  wire logic        enable,
	input  wire logic [15:0] halfPeriod,
	output logic             refClock
);
	logic [15:0] count_r;
	initial refClock = 1'b0;
	initial count_r = 16'h0000;
	always @(posedge clock)
	begin
		if (!enable)
		begin
			count_r  <= 16'h0000;
			refClock <= 1'b0;
		end
		else if (count_r >= halfPeriod - 16'h0001)
		begin
			count_r  <= 16'h0000;
			refClock <= ~refClock;
		end
		else
			count_r <= count_r + 16'h0001;
	end
endmodule : ref_clock_source
`default_nettype wire

// file: tb_pll_counter_clock_synthesis.sv
// self-checking testbench for the clock synthesis core
`timescale 1ns/100ps
`default_nettype none
module tb_pll_counter_clock_synthesis;
	import pll_synth_pkg::*;
	logic        clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, refClockIn, refRun;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [15:0] refHalf;
	logic [4:0]  globalClockOut, cascClockOut;
	logic        extClockPosOut, extClockPosOeN, extClockNegOut, extClockNegOeN;
	logic        extClockPosIn, extClockNegIn;
	int          error_cnt, num_checks;
	// pins pulled low when nobody drives them
	assign extClockPosIn = extClockPosOeN ? 1'b0 : extClockPosOut;
	assign extClockNegIn = extClockNegOeN ? 1'b0 : extClockNegOut;
	ref_clock_source ref_clock_source_i (.clock, .enable(refRun), .halfPeriod(refHalf),
		.refClock(refClockIn));
	pll_counter_clock_synthesis pll_counter_clock_synthesis_i (.clock, .reset, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.refClockIn, .globalClockOut, .extClockPosIn, .extClockPosOut, .extClockPosOeN,
		.extClockNegIn, .extClockNegOut, .extClockNegOeN);
	// divider zero feeds divider one in this copy
	pll_counter_clock_synthesis #(.CASCADE_MASK(4'h1)) pll_counter_clock_synthesis_c_i (
		.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o(), .wb_ack_o(), .refClockIn, .globalClockOut(cascClockOut),
		.extClockPosIn, .extClockPosOut(), .extClockPosOeN(), .extClockNegIn,
		.extClockNegOut(), .extClockNegOeN());
	always #5 clock = ~clock;
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic near(input string nm, input int e, input int g, input int t);
		num_checks++;
		if (g < e - t || g > e + t)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask : near
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check("ackSeen", 32'h1, {31'h0, wb_ack_o});
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hF, q);
	endtask : wr
	task automatic test_reset_values;
		logic [31:0] q;
		wb(1'b0, CTRL_OFS, 32'h0, 4'hF, q);
		check("ctrlReset", 32'h0, q);
		wb(1'b0, PRESCALE_OFS, 32'h0, 4'hF, q);
		check("prescaleReset", 32'h1, q);
		wb(1'b0, MULT_OFS, 32'h0, 4'hF, q);
		check("multReset", 32'h1, q);
		for (int i = 0; i < 5; i++)
		begin
			wb(1'b0, DIV_BASE_OFS + 8'(4 * i), 32'h0, 4'hF, q);
			check("dividerReset", 32'h0001_0001, q);
		end
		$display("test reset values done");
	endtask : test_reset_values
	task automatic test_register_access;
		logic [31:0] q;
		wr(PRESCALE_OFS, 32'h0000_0200);
		wb(1'b0, PRESCALE_OFS, 32'h0, 4'hF, q);
		check("prescaleMax", 32'h0000_0200, q);
		wb(1'b1, MULT_OFS, 32'hFFFF_FFFF, 4'h1, q);
		wb(1'b0, MULT_OFS, 32'h0, 4'hF, q);
		check("multLaneMerge", 32'h0000_00FF, q);
		wr(DIV_BASE_OFS, 32'h0100_0100);
		wb(1'b0, DIV_BASE_OFS, 32'h0, 4'hF, q);
		check("dividerMax", 32'h0100_0100, q);
		wr(8'hF0, 32'h1234_5678);
		wb(1'b0, 8'hF0, 32'h0, 4'hF, q);
		check("unmapped", 32'h0, q);
		wr(CTRL_OFS, 32'h0000_0007);
		wb(1'b0, STATUS_OFS, 32'h0, 4'hF, q);
		check("badModeFlag", 32'h1, {31'h0, q[CFG_ERR_BIT]});
		wr(CTRL_OFS, 32'h0000_0100);
		wb(1'b0, CTRL_OFS, 32'h0, 4'hF, q);
		check("restartNotStored", 32'h0, q);
		$display("test register access done");
	endtask : test_register_access
	task automatic test_synthesis;
		logic [7:0]  cc [5] = '{8'h20, 8'h91, 8'h2A, 8'h13, 8'hD4};
		int          cn [5] = '{1, 2, 1, 1, 1};
		int          cm [5] = '{2, 2, 4, 4, 1};
		int          ch [5] = '{1, 1, 3, 2, 0};
		int          cl [5] = '{1, 1, 1, 2, 2};
		logic [31:0] st;
		int          k, ticks, e0, e1, c1, hi, mis;
		logic        p0, p1, pc;
		for (int i = 0; i < 5; i++)
		begin
			wr(PRESCALE_OFS, 32'(cn[i]));
			wr(MULT_OFS, 32'(cm[i]));
			wr(DIV_BASE_OFS, (32'(cl[i]) << DIV_LOW_LSB) | 32'(ch[i]));
			wr(CTRL_OFS, {24'h0, cc[i]});
			k = 0;
			do
			begin
				wb(1'b0, STATUS_OFS, 32'h0, 4'hF, st);
				k++;
			end
			while (st[LOCKED_BIT] !== 1'b1 && k < 400);
			check("locked", 32'h1, {31'h0, st[LOCKED_BIT]});
			if (cc[i][7])
				check("userIoPin", {31'h0, cc[i][6]}, {31'h0, st[NEG_PIN_BIT]});
			e0 = 0;
			e1 = 0;
			c1 = 0;
			hi = 0;
			mis = 0;
			{p0, p1, pc} = 3'h7;
			repeat (640)
			begin
				@(posedge clock);
				e0 += int'(globalClockOut[0] && !p0);
				e1 += int'(globalClockOut[1] && !p1);
				c1 += int'(cascClockOut[1] && !pc);
				hi += int'(globalClockOut[0]);
				mis += int'(globalClockOut[0] != globalClockOut[1]);
				{p0, p1, pc} = {globalClockOut[0], globalClockOut[1], cascClockOut[1]};
			end
			ticks = 640 * cm[i] / (2 * int'(refHalf) * cn[i] * (cc[i][3] ? 2 : 1));
			near("div0Edges", ch[i] ? ticks / (ch[i] + cl[i]) : 0, e0, 1);
			near("div1Edges", ticks / 2, e1, 1);
			if (ch[i] != 0)
				near("cascadeEdges", ticks / ((ch[i] + cl[i]) * 2), c1, 1);
			if (ch[i] != 0 && ch[i] != cl[i])
				near("highTime", 640 * ch[i] / (ch[i] + cl[i]), hi, 40);
			if (ch[i] == 1 && cl[i] == 1 && cc[i][2:0] == 3'h0)
				check("alignedOutputs", 32'h0, 32'(mis));
		end
		$display("test synthesis done");
	endtask : test_synthesis
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		$display("CHECK FAILED watchdog expected end seen hang");
		give_verdict();
	end
	initial
	begin
		{clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, refRun} = 6'h13;
		{wb_adr_i, wb_sel_i, wb_dat_i, refHalf} = '0;
		error_cnt = 0;
		num_checks = 0;
		refHalf = 16'h0014;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		test_reset_values();
		test_register_access();
		test_synthesis();
		give_verdict();
	end
endmodule : tb_pll_counter_clock_synthesis
`default_nettype wire
